/* File: ufrt_pkg.sv */
package ufrt_pkg;

  // ------------------------------------------------------------------
  // Register map and field layout
  // ------------------------------------------------------------------
  localparam logic [7:0] UFRT_OFS_BIT_TIME_LEFT = 8'h38;
  localparam logic [7:0] UFRT_OFS_FRAME_COUNT = 8'h3C;
  localparam int UFRT_LEFT_W = 14;
  localparam int UFRT_COUNT_W = 16;
  localparam int UFRT_TOGGLE_POS = 31;
  localparam int UFRT_SOF_FLAG_POS = 2;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [13:0] UFRT_LEFT_RST = 14'h0000;
  localparam logic [15:0] UFRT_COUNT_RST = 16'h0000;
  localparam logic [13:0] UFRT_INTERVAL_NOMINAL = 14'h2EDF;
  localparam logic [31:0] UFRT_RDATA_RST = 32'h0000_0000;

  // Register access request from the memory window decoder.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } ufrt_req_s;

  // Frame boundary sequence.
  typedef enum logic [1:0] {
    UFRT_IDLE,
    UFRT_HCCA_WRITE,
    UFRT_FLAG
  } ufrt_state_e;

endpackage

/* File: ufrt_counters.sv */
`timescale 1ns/1ps
module ufrt_counters
  import ufrt_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Register access
  input wire ufrt_req_s reg_req_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Frame timing controls
  input wire logic bit_tick_toggle_i,
  input wire logic frames_running_i,
  input wire logic operational_entry_i,
  input wire logic [13:0] frame_interval_i,
  input wire logic interval_toggle_i,
  // Frame boundary events
  output logic sof_send_o,
  output logic hcca_wr_req_o,
  output logic [15:0] hcca_frame_o,
  input wire logic hcca_wr_done_i,
  output logic start_of_frame_flag_o,
  output logic ed_fetch_allow_o
);

  // ------------------------------------------------------------------
  // Bit-time tick crossing
  // ------------------------------------------------------------------
  // Synchroniser and edge memory for the bit-time toggle.
  logic tick_meta_r;
  logic tick_sync_r;
  logic tick_prev_r;

  // Counter state and the interval that it reloads from.
  logic [13:0] interval_r;
  logic [13:0] bit_times_left_r;
  logic remaining_toggle_r;
  logic [15:0] frame_count_value_r;

  // Position in the frame boundary sequence.
  ufrt_state_e state_r;

  // The tick toggles in the full-speed domain; each edge is one bit time.
  // A toggle survives the slower clock where a pulse would not, but it
  // must hold across at least one clock edge or an edge is missed.
  // The third flop only remembers the last synchronised level.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_meta_r <= 1'b0;
      tick_sync_r <= 1'b0;
      tick_prev_r <= 1'b0;
    end else begin
      tick_meta_r <= bit_tick_toggle_i;
      tick_sync_r <= tick_meta_r;
      tick_prev_r <= tick_sync_r;
    end
  end

  // Either edge of the synchronised toggle marks one bit time.
  wire bit_tick = tick_sync_r ^ tick_prev_r;

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  // Offsets compare on the full byte address, so unmapped ones select nothing.
  function automatic logic ufrt_hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  wire sel_left = ufrt_hit(reg_req_i.addr, UFRT_OFS_BIT_TIME_LEFT);
  wire sel_count = ufrt_hit(reg_req_i.addr, UFRT_OFS_FRAME_COUNT);
  wire wr_left = reg_req_i.wr && sel_left;
  wire wr_count = reg_req_i.wr && sel_count;
  // A boundary needs a bit time, while an entry pulse starts a frame alone.
  wire tick_run = bit_tick && frames_running_i;
  wire at_zero = (bit_times_left_r == 14'h0000);
  wire reload = tick_run && at_zero;
  wire advance = reload || operational_entry_i;

  // ------------------------------------------------------------------
  // Frame interval capture
  // ------------------------------------------------------------------
  // Loads the nominal interval at reset, then follows frame_interval_i
  // every clock, so frames start at whatever length is presented.
  // A new interval reaches the counter one clock late, which is far
  // inside one bit time and so never shifts a boundary.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      interval_r <= UFRT_INTERVAL_NOMINAL;
    end else begin
      interval_r <= frame_interval_i;
    end
  end

  // ------------------------------------------------------------------
  // Bit times left in the frame
  // ------------------------------------------------------------------
  // Hardware reload and decrement win over a software write in the same
  // cycle, so a frame boundary is never lost.
  // Entry reloads the count but leaves the toggle; only a boundary copies it.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bit_times_left_r <= UFRT_LEFT_RST;
      remaining_toggle_r <= 1'b0;
    end else if (operational_entry_i) begin
      bit_times_left_r <= interval_r;
    end else if (reload) begin
      bit_times_left_r <= interval_r;
      remaining_toggle_r <= interval_toggle_i;
    end else if (tick_run) begin
      bit_times_left_r <= bit_times_left_r - 14'h0001;
    end else if (wr_left) begin
      bit_times_left_r <= reg_req_i.wdata[UFRT_LEFT_W-1:0];
      remaining_toggle_r <= reg_req_i.wdata[UFRT_TOGGLE_POS];
    end
  end

  // ------------------------------------------------------------------
  // Frame count
  // ------------------------------------------------------------------
  // Plain 16-bit add wraps from all ones to zero by itself.
  // A software write loses to an advance in the same clock, because a
  // register poke must never swallow a frame.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      frame_count_value_r <= UFRT_COUNT_RST;
    end else if (advance) begin
      frame_count_value_r <= frame_count_value_r + 16'h0001;
    end else if (wr_count) begin
      frame_count_value_r <= reg_req_i.wdata[UFRT_COUNT_W-1:0];
    end
  end

  // ------------------------------------------------------------------
  // Frame boundary sequence
  // ------------------------------------------------------------------
  // The count is published one cycle after it advances, so the shared
  // area always receives the new value; the flag follows the write.
  // A boundary that lands before the sequence is idle again still counts,
  // but it gets no second write and no second flag.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= UFRT_IDLE;
      sof_send_o <= 1'b0;
      hcca_wr_req_o <= 1'b0;
      hcca_frame_o <= UFRT_COUNT_RST;
      start_of_frame_flag_o <= 1'b0;
      ed_fetch_allow_o <= 1'b0;
    end else begin
      sof_send_o <= 1'b0;
      start_of_frame_flag_o <= 1'b0;
      case (state_r)
        UFRT_IDLE: begin
          if (advance) begin
            state_r <= UFRT_HCCA_WRITE;
            sof_send_o <= 1'b1;
            ed_fetch_allow_o <= 1'b0;
          end
        end
        UFRT_HCCA_WRITE: begin
          // The word is latched once, so a later advance cannot move it in flight.
          if (!hcca_wr_req_o) begin
            hcca_wr_req_o <= 1'b1;
            hcca_frame_o <= frame_count_value_r;
          end else if (hcca_wr_done_i) begin
            hcca_wr_req_o <= 1'b0;
            state_r <= UFRT_FLAG;
          end
        end
        UFRT_FLAG: begin
          // The flag and the fetch release share one edge, after the write.
          start_of_frame_flag_o <= 1'b1;
          ed_fetch_allow_o <= 1'b1;
          state_r <= UFRT_IDLE;
        end
        default: begin
          // An illegal state falls back to idle and waits for a boundary.
          state_r <= UFRT_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------------
  // Reserved bits read as zero; an unmapped offset reads all zero.
  wire [31:0] left_word = {remaining_toggle_r, 17'h00000, bit_times_left_r};
  wire [31:0] count_word = {16'h0000, frame_count_value_r};
  wire [31:0] rd_mux = sel_left ? left_word : (sel_count ? count_word : 32'h0000_0000);

  // The answer comes one clock after the strobe, whichever offset it hit.
  // Data is forced to zero outside an answer, so no stale word leaks out.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= UFRT_RDATA_RST;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_req_i.rd;
      reg_rdata_o <= reg_req_i.rd ? rd_mux : UFRT_RDATA_RST;
    end
  end

endmodule

/* File: ufrt_counters_props.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Port checker for the frame timing counters
// ------------------------------------------------------------------
module ufrt_counters_chk
  import ufrt_pkg::*;
(
  // Clock, reset and every port of the block
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire ufrt_req_s reg_req_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic bit_tick_toggle_i,
  input wire logic frames_running_i,
  input wire logic operational_entry_i,
  input wire logic [13:0] frame_interval_i,
  input wire logic interval_toggle_i,
  input wire logic sof_send_o,
  input wire logic hcca_wr_req_o,
  input wire logic [15:0] hcca_frame_o,
  input wire logic hcca_wr_done_i,
  input wire logic start_of_frame_flag_o,
  input wire logic ed_fetch_allow_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Reads answer on the next cycle and the data bus stays clean otherwise.
  a_read_answer: assert property (reg_req_i.rd |=> reg_rvalid_o)
    else $error("read gave no answer");
  a_rdata_idle_zero: assert property (!reg_rvalid_o |-> reg_rdata_o == 32'h0)
    else $error("read data not zero while idle");
  // The shared area write must follow the SOF and hold the list fetch off.
  a_sof_then_write: assert property (sof_send_o |=> !sof_send_o && hcca_wr_req_o)
    else $error("no shared area write after sof");
  a_fetch_held_off: assert property (hcca_wr_req_o |-> !ed_fetch_allow_o)
    else $error("list fetch allowed during shared area write");
  a_frame_value_steady: assert property (
    hcca_wr_req_o && $past(hcca_wr_req_o) |-> $stable(hcca_frame_o))
    else $error("frame value moved during write");
  // The status flag comes only after the write has completed.
  a_flag_after_write: assert property (
    hcca_wr_req_o && hcca_wr_done_i |=> !hcca_wr_req_o ##1 start_of_frame_flag_o)
    else $error("flag missing after write");
  a_flag_pulse: assert property (start_of_frame_flag_o |=> !start_of_frame_flag_o)
    else $error("flag longer than one cycle");
  a_flag_frees_fetch: assert property (
    start_of_frame_flag_o |-> ed_fetch_allow_o && !hcca_wr_req_o)
    else $error("fetch not released with flag");
  c_sof: cover property (sof_send_o);
  c_flag: cover property (start_of_frame_flag_o);
  c_read: cover property (reg_rvalid_o);
endmodule

bind ufrt_counters ufrt_counters_chk u_chk (.*);

/* File: usb_frame_timing_counters_test.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Self-checking bench for the frame timing counters
// ------------------------------------------------------------------
module usb_frame_timing_counters_test
  import ufrt_pkg::*;
;
  logic ref_clk_i = 0, rst_b_i = 0, tick = 0, run = 0, entry = 0, itog = 0, done = 0;
  logic rvalid, sof, hreq, flag, fetch, hreq_q = 0;
  logic [13:0] ival = 14'h0003;
  logic [15:0] hframe;
  logic [31:0] rdata;
  ufrt_req_s req = '0;
  logic [31:0] rq[$];
  logic [15:0] fq[$];
  int n_mismatch = 0, checks_done = 0;
  int n_sof = 0, n_flag = 0;

  ufrt_counters dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .bit_tick_toggle_i(tick),
    .frames_running_i(run), .operational_entry_i(entry), .frame_interval_i(ival),
    .interval_toggle_i(itog), .sof_send_o(sof), .hcca_wr_req_o(hreq),
    .hcca_frame_o(hframe), .hcca_wr_done_i(done), .start_of_frame_flag_o(flag),
    .ed_fetch_allow_o(fetch));

  // Clock of 50 ns period.
  initial forever #25 ref_clk_i = ~ref_clk_i;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    if (rq.size() != 0 || fq.size() != 0) n_mismatch++;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
    #2;
  endtask

  // One register access; for a read, d is the expected word.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    req = '{w, !w, a, d};
    if (!w) rq.push_back(d);
    step(1);
    req = '0;
    step(1);
  endtask

  // Each tick change waits out the two-flop synchroniser before the next.
  task automatic tickn(input int n);
    repeat (n) begin
      tick = ~tick;
      step(6);
    end
  endtask

  // Observe settled outputs on the falling edge; a result with no note is a mismatch.
  always @(negedge ref_clk_i) begin
    if (rvalid === 1'b1) begin
      check({31'h0, rq.size() != 0}, 32'h1);
      if (rq.size() != 0) check(rdata, rq.pop_front());
    end
    if (hreq === 1'b1 && hreq_q !== 1'b1) begin
      check({31'h0, fq.size() != 0}, 32'h1);
      if (fq.size() != 0) check({16'h0, hframe}, {16'h0, fq.pop_front()});
    end
    if (sof === 1'b1) begin
      n_sof++;
      check({30'h0, hreq, fetch}, 32'h0);
    end
    if (flag === 1'b1) begin
      n_flag++;
      check({30'h0, hreq, fetch}, 32'h1);
    end
    hreq_q = hreq;
  end

  // Hang guard.
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_mismatch++;
    conclude;
  end

  initial begin
    void'($urandom(32'hd057));
    // Shared area writes complete after a random delay; the forked responder
    // inherits the seeded stream, so the run repeats exactly.
    fork
      forever begin
        @(posedge ref_clk_i);
        done <= #2 hreq & ($urandom_range(1) == 1);
      end
    join_none
    step(10);
    rst_b_i = 1;
    step(1);
    bus(0, UFRT_OFS_BIT_TIME_LEFT, 32'h0);
    bus(0, UFRT_OFS_FRAME_COUNT, 32'h0);
    bus(0, 8'h40, 32'h0);
    run = 1;
    fq.push_back(16'h0001);
    entry = 1;
    step(1);
    entry = 0;
    step(20);
    bus(0, UFRT_OFS_BIT_TIME_LEFT, 32'h3);
    bus(0, UFRT_OFS_FRAME_COUNT, 32'h1);
    ival = 14'h0004;
    itog = 1;
    tickn(1);
    bus(0, UFRT_OFS_BIT_TIME_LEFT, 32'h2);
    tickn(1);
    bus(0, UFRT_OFS_BIT_TIME_LEFT, 32'h1);
    fq.push_back(16'h0002);
    tickn(2);
    step(20);
    bus(0, UFRT_OFS_BIT_TIME_LEFT, 32'h8000_0004);
    bus(0, UFRT_OFS_FRAME_COUNT, 32'h2);
    bus(1, UFRT_OFS_FRAME_COUNT, 32'h0000_FFFF);
    bus(0, UFRT_OFS_FRAME_COUNT, 32'h0000_FFFF);
    fq.push_back(16'h0000);
    tickn(5);
    step(20);
    // A driver that extends the count to 32 bits relies on this rollover.
    bus(0, UFRT_OFS_FRAME_COUNT, 32'h0);
    bus(1, UFRT_OFS_BIT_TIME_LEFT, 32'h0000_0005);
    bus(0, UFRT_OFS_BIT_TIME_LEFT, 32'h0000_0005);
    run = 0;
    tickn(1);
    bus(0, UFRT_OFS_BIT_TIME_LEFT, 32'h0000_0005);
    check(n_sof, 32'h3);
    check(n_flag, 32'h3);
    conclude;
  end
endmodule
